// ### lcdh_core.sv
// character display host interface: bus, serial link, address counter and RAMs
`timescale 1ns/1ps
`default_nettype none

// Contract
// [R01] plain set: top bit loads text address
// [R02] two-line map 00-27h and 40-67h
// [R03] four-line map 00-13,20-33,40-53,60-73h
// [R04] extended set: top bit sets burst length
// [R05] host sends burst command before data
// [R06] status read gives busy and address
// [R07] host waits while busy reads high
// [R08] data write stores into selected RAM
// [R09] each data access steps the address
// [R10] first read after no address invalid
// [R11] cursor shift preloads read data register
// [R12] four-bit bus: high nibble then low
// [R13] four-bit busy rises after second nibble
// [R14] eight-bit bus: one access per byte
// [R15] pick input high parallel, low serial
// [R16] four-pin serial uses select, data, clock
// [R17] serial clock idles high, rising sample
// [R18] three-pin serial: burst separates instruction/data
// [R19] power-up fills spaces, busy held high
// [R20] init: 8-bit, plain set, bank mode
// [R21] init: display off, increment, fields zero
// [R22] hardware reset reinitialises, ignored during power-up
// [R23] extended bit gates shared opcodes
// [R24] step direction: set up, clear down
// [R25] width bit: high 8-bit, low 4-bit
// [R26] serial byte: 8 bits MSB first, framed
module lcdh_core
	import lcdh_pkg::*;
	#(
	parameter int EXEC_CYCLES = EXEC_CYCLES_CALC
	)
	(
	input wire logic clk,
	input wire logic clk_en,
	input wire logic reset_n,
	input wire logic serial_clk,
	input wire lcdh_pins_t pin_in,
	output logic [7:0] db_out,
	output logic db_oe_n,
	output logic busy_flag,
	output logic [6:0] address_counter,
	output var lcdh_cfg_t display_cfg
	);

	// refuse execution times the counter cannot hold
	if (EXEC_CYCLES < 1 || EXEC_CYCLES > 255)
	begin : g_bad_exec
		$error("EXEC_CYCLES out of range");
	end

	lcdh_state_t state_ff; // system domain state
	lcdh_state_t nxt_state; // its next value
	lcdh_link_t link_ff; // serial domain state
	lcdh_link_t nxt_link; // its next value
	logic [2:0] bit_cnt_ff; // bit position within a serial byte
	logic frame_rst_n; // clears the bit count outside a frame

	logic [7:0] text_ram [TEXT_DEPTH]; // display text
	logic [7:0] font_ram [FONT_DEPTH]; // user fonts
	logic [7:0] icon_ram [ICON_DEPTH]; // icons

	logic ev_valid; // a whole byte arrived this cycle
	logic ev_exec; // byte is acted upon
	logic ev_data; // byte is data, not instruction
	logic ev_read; // byte slot is a read
	logic [7:0] ev_byte; // the byte itself
	logic lk_event; // serial byte handed over
	logic [7:0] lk_byte; // serial byte from the held slot
	logic lk_isel; // its data/instruction sample
	logic pf_load; // reload the read data register
	logic wr_en; // RAM write strobe
	lcdh_ram_t wr_ram; // RAM written
	logic [6:0] wr_addr; // write address
	logic [7:0] wr_data; // write data
	logic [7:0] rd_val; // value offered on a bus read

	// address step with line wrap for text, plain wrap for the small RAMs
	function automatic logic [6:0] lcdh_step(input logic [6:0] cur, input logic up,
		input lcdh_ram_t ram, input logic four);
		logic [6:0] r;
		r = up ? cur + 7'h01 : cur - 7'h01; // see [R09] [R24]
		if (ram == RAM_FONT)
			r = {1'b0, r[5:0]};
		else if (ram == RAM_ICON)
			r = {3'h0, r[3:0]};
		else if (!four)
		begin
			// two lines of forty cells
			if (up && cur == L2_LINE1_END)
				r = L2_LINE2_BASE; // see [R02]
			else if (up && cur == L2_LINE2_END)
				r = AC_RESET; // see [R02]
			else if (!up && cur == AC_RESET)
				r = L2_LINE2_END; // see [R02]
			else if (!up && cur == L2_LINE2_BASE)
				r = L2_LINE1_END; // see [R02]
		end
		else
		begin
			// four lines of twenty cells on 20h boundaries
			if (up && cur[4:0] == L4_LAST_COL)
				r = {cur[6:5] + 2'h1, 5'h00}; // see [R03]
			else if (!up && cur[4:0] == 5'h00)
				r = {cur[6:5] - 2'h1, L4_LAST_COL}; // see [R03]
		end
		return r;
	endfunction

	// serial shifter: sample on rising clock, msb first, inside a frame
	always_comb
	begin
		nxt_link = link_ff;
		nxt_link.shreg = {link_ff.shreg[5:0], pin_in.db[SER_DATA_BIT]}; // see [R17] [R26]
		if (bit_cnt_ff == 3'h7)
		begin
			// alternate slots so the other domain has two bytes of time
			if (link_ff.tog)
			begin
				nxt_link.buf1 = {link_ff.shreg, pin_in.db[SER_DATA_BIT]};
				nxt_link.isel1 = pin_in.instr_data_select; // see [R16]
			end
			else
			begin
				nxt_link.buf0 = {link_ff.shreg, pin_in.db[SER_DATA_BIT]};
				nxt_link.isel0 = pin_in.instr_data_select; // see [R16]
			end
			nxt_link.tog = ~link_ff.tog;
		end
	end

	// link register, clocked only while chip select is low
	always_ff @(posedge serial_clk or negedge reset_n)
	begin
		if (!reset_n)
			link_ff <= LINK_RESET;
		else if (!pin_in.db[SER_CS_BIT])
			link_ff <= nxt_link;
	end

	// chip select high drops a partial byte
	assign frame_rst_n = reset_n & ~pin_in.db[SER_CS_BIT]; // see [R26]

	// bit counter of the current frame
	always_ff @(posedge serial_clk or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			bit_cnt_ff <= 3'h0;
		else
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
	end

	// main next-state logic
	always_comb
	begin
		nxt_state = state_ff;
		ev_valid = 1'b0;
		ev_data = 1'b0;
		ev_read = 1'b0;
		ev_byte = 8'h00;
		pf_load = 1'b0;
		wr_en = 1'b0;
		wr_ram = RAM_TEXT;
		wr_addr = 7'h00;
		wr_data = 8'h00;
		// pins and the link toggle pass two flops first
		nxt_state.s1 = pin_in;
		nxt_state.s2 = state_ff.s1;
		nxt_state.e_prev = state_ff.s2.enable;
		nxt_state.tog_s1 = link_ff.tog;
		nxt_state.tog_s2 = state_ff.tog_s1;
		nxt_state.tog_seen = state_ff.tog_s2;
		lk_event = state_ff.tog_s2 != state_ff.tog_seen;
		lk_byte = state_ff.tog_seen ? link_ff.buf1 : link_ff.buf0;
		lk_isel = state_ff.tog_seen ? link_ff.isel1 : link_ff.isel0;
		if (state_ff.busy_cnt != 8'h00)
			nxt_state.busy_cnt = state_ff.busy_cnt - 8'h01;
		// byte assembly from the parallel bus or the serial link
		if (state_ff.s2.parallel_serial_pick && state_ff.e_prev && !state_ff.s2.enable) // see [R15]
		begin
			ev_data = state_ff.s2.instr_data_select;
			ev_read = state_ff.s2.read_select;
			if (state_ff.cfg.bus_8bit) // see [R25]
			begin
				ev_valid = 1'b1;
				ev_byte = state_ff.s2.db; // see [R14]
			end
			else if (!state_ff.nib_phase)
			begin
				// high nibble first, nothing happens yet
				nxt_state.nib_hi = state_ff.s2.db[7:4]; // see [R12] [R13]
				nxt_state.nib_phase = 1'b1;
			end
			else
			begin
				ev_valid = 1'b1;
				ev_byte = {state_ff.nib_hi, state_ff.s2.db[7:4]}; // see [R12]
				nxt_state.nib_phase = 1'b0;
			end
		end
		else if (!state_ff.s2.parallel_serial_pick && lk_event) // see [R15]
		begin
			ev_valid = 1'b1;
			ev_byte = lk_byte;
			// three-pin: the burst count alone says what is data
			ev_data = state_ff.s2.three_pin_pick ? (state_ff.burst_left != 7'h00) : lk_isel; // see [R18] [R05]
		end
		// fill sequencer writes spaces while busy stays high
		if (state_ff.seq == SEQ_FILL)
		begin
			wr_en = 1'b1;
			wr_addr = state_ff.fill_addr;
			wr_data = SPACE_CODE; // see [R19]
			nxt_state.fill_addr = state_ff.fill_addr + 7'h01;
			if (state_ff.fill_addr == TEXT_LAST)
			begin
				nxt_state.seq = SEQ_IDLE;
				nxt_state.por_active = 1'b0;
			end
		end
		ev_exec = ev_valid && state_ff.seq == SEQ_IDLE;
		if (ev_exec && ev_data && !ev_read)
		begin
			// data write into the RAM picked by the last address set
			wr_en = 1'b1;
			wr_ram = state_ff.target; // see [R08]
			wr_addr = state_ff.address_counter;
			wr_data = ev_byte;
			nxt_state.address_counter = lcdh_step(state_ff.address_counter,
				state_ff.cfg.entry_increment, state_ff.target, state_ff.cfg.four_line_mode); // see [R09]
			nxt_state.busy_cnt = EXEC_CYCLES[7:0];
			if (!state_ff.s2.parallel_serial_pick && state_ff.s2.three_pin_pick
				&& state_ff.burst_left != 7'h00)
				nxt_state.burst_left = state_ff.burst_left - 7'h01; // see [R18]
		end
		else if (ev_exec && ev_data)
		begin
			// data read: step, then fetch the next byte; stale after writes
			nxt_state.address_counter = lcdh_step(state_ff.address_counter,
				state_ff.cfg.entry_increment, state_ff.target, state_ff.cfg.four_line_mode); // see [R09] [R10]
			pf_load = 1'b1;
			nxt_state.busy_cnt = EXEC_CYCLES[7:0];
		end
		else if (ev_exec && !ev_read)
		begin
			// instruction decode by leading bit, gated by the extended bit
			nxt_state.busy_cnt = EXEC_CYCLES[7:0];
			if (ev_byte[OP_TEXT_ADDR_BIT])
			begin
				if (!state_ff.cfg.extended_set_select) // see [R23]
				begin
					nxt_state.address_counter = ev_byte[6:0]; // see [R01]
					nxt_state.target = RAM_TEXT;
					pf_load = 1'b1;
				end
				else
				begin
					nxt_state.cfg.spi_burst_length = ev_byte[6:0]; // see [R04]
					nxt_state.burst_left = (ev_byte[6:0] > BURST_MAX_FIELD) ?
						BURST_MAX_FIELD + 7'h01 : ev_byte[6:0] + 7'h01; // see [R04]
				end
			end
			else if (ev_byte[OP_FONT_ADDR_BIT])
			begin
				pf_load = 1'b1;
				if (!state_ff.cfg.extended_set_select) // see [R23]
				begin
					nxt_state.address_counter = {1'b0, ev_byte[5:0]};
					nxt_state.target = RAM_FONT;
				end
				else
				begin
					nxt_state.address_counter = {3'h0, ev_byte[3:0]};
					nxt_state.target = RAM_ICON;
				end
			end
			else if (ev_byte[OP_FUNC_BIT])
			begin
				nxt_state.cfg.bus_8bit = ev_byte[FS_WIDTH_BIT]; // see [R25]
				nxt_state.cfg.extended_set_select = ev_byte[FS_EXT_BIT]; // see [R23]
				nxt_state.nib_phase = 1'b0;
				if (!ev_byte[FS_EXT_BIT])
				begin
					nxt_state.cfg.shift_or_bank_pick = ev_byte[1];
					nxt_state.cfg.invert_all = ev_byte[0];
				end
				else
					nxt_state.cfg.user_font_blink = ev_byte[1];
			end
			else if (ev_byte[OP_SHIFT_BIT])
			begin
				if (!state_ff.cfg.extended_set_select)
				begin
					// cursor move steps the text address; display shift keeps it
					if (!ev_byte[3])
					begin
						nxt_state.address_counter = lcdh_step(state_ff.address_counter,
							ev_byte[2], RAM_TEXT, state_ff.cfg.four_line_mode);
						nxt_state.target = RAM_TEXT;
						pf_load = 1'b1; // see [R11]
					end
				end
				else if (state_ff.cfg.shift_or_bank_pick)
					nxt_state.cfg.line_scroll_enables = ev_byte[3:0];
				else
					nxt_state.cfg.code_bank = ev_byte[1:0];
			end
			else if (ev_byte[OP_DISP_BIT])
			begin
				if (!state_ff.cfg.extended_set_select)
				begin
					nxt_state.cfg.display_on = ev_byte[2];
					nxt_state.cfg.cursor_on = ev_byte[1];
					nxt_state.cfg.blink_on = ev_byte[0];
				end
				else
				begin
					nxt_state.cfg.cursor_invert = ev_byte[1];
					nxt_state.cfg.four_line_mode = ev_byte[0];
				end
			end
			else if (ev_byte[OP_ENTRY_BIT])
			begin
				if (!state_ff.cfg.extended_set_select)
				begin
					nxt_state.cfg.entry_increment = ev_byte[1]; // see [R24]
					nxt_state.cfg.entry_shift = ev_byte[0];
				end
				else
					nxt_state.cfg.segment_order_flip = ev_byte[0];
			end
			else if (ev_byte[OP_HOME_BIT])
			begin
				if (!state_ff.cfg.extended_set_select)
				begin
					nxt_state.address_counter = AC_RESET;
					nxt_state.target = RAM_TEXT;
				end
				else
					nxt_state.cfg.power_down = ev_byte[0];
			end
			else if (ev_byte[OP_CLEAR_BIT])
			begin
				// clear: refill with spaces, home, increment
				nxt_state.seq = SEQ_FILL;
				nxt_state.fill_addr = 7'h00;
				nxt_state.address_counter = AC_RESET;
				nxt_state.target = RAM_TEXT;
				nxt_state.cfg.entry_increment = 1'b1;
			end
		end
		// hardware reset pin restarts init unless power-up init runs
		if (!state_ff.s2.hw_reset_n && !state_ff.por_active) // see [R22]
		begin
			nxt_state.cfg = CFG_RESET; // see [R20] [R21]
			nxt_state.address_counter = AC_RESET;
			nxt_state.target = RAM_TEXT;
			nxt_state.seq = SEQ_FILL;
			nxt_state.fill_addr = 7'h00;
			nxt_state.burst_left = 7'h00;
			nxt_state.nib_phase = 1'b0;
		end
		// output data register reload from the current target
		if (pf_load)
		begin
			unique case (nxt_state.target)
				RAM_TEXT: nxt_state.rd_data = text_ram[nxt_state.address_counter];
				RAM_FONT: nxt_state.rd_data = font_ram[nxt_state.address_counter[5:0]];
				RAM_ICON: nxt_state.rd_data = icon_ram[nxt_state.address_counter[3:0]];
				default: nxt_state.rd_data = state_ff.rd_data;
			endcase
		end
		nxt_state.busy = nxt_state.seq != SEQ_IDLE || nxt_state.busy_cnt != 8'h00; // see [R19]
		// drive the bus while enable is high on a read
		rd_val = state_ff.s2.instr_data_select ? state_ff.rd_data
			: {state_ff.busy, state_ff.address_counter}; // see [R06]
		nxt_state.db_oe_n = !(state_ff.s2.parallel_serial_pick && state_ff.s2.enable
			&& state_ff.s2.read_select);
		nxt_state.db_out = (!state_ff.cfg.bus_8bit && state_ff.nib_phase) ?
			{rd_val[3:0], 4'h0} : rd_val; // see [R12]
	end

	// state register, frozen while clk_en is low
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state_ff <= ST_RESET; // see [R19] [R20] [R21]
		else if (clk_en)
			state_ff <= nxt_state;
	end

	// RAM write port
	always_ff @(posedge clk)
	begin
		if (clk_en && wr_en && wr_ram == RAM_TEXT)
			text_ram[wr_addr] <= wr_data;
		if (clk_en && wr_en && wr_ram == RAM_FONT)
			font_ram[wr_addr[5:0]] <= wr_data;
		if (clk_en && wr_en && wr_ram == RAM_ICON)
			icon_ram[wr_addr[3:0]] <= wr_data;
	end

	assign db_out = state_ff.db_out;
	assign db_oe_n = state_ff.db_oe_n;
	assign busy_flag = state_ff.busy;
	assign address_counter = state_ff.address_counter;
	assign display_cfg = state_ff.cfg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// accepted instruction with the top bit set
	sequence s_addr_cmd;
		clk_en && ev_exec && !ev_data && !ev_read && ev_byte[OP_TEXT_ADDR_BIT]
			&& state_ff.s2.hw_reset_n;
	endsequence
	// accepted data access
	sequence s_data_access;
		clk_en && ev_exec && ev_data && state_ff.s2.hw_reset_n;
	endsequence
	// parallel status read slot, either bus width
	sequence s_status_rd;
		clk_en && state_ff.s2.parallel_serial_pick && state_ff.s2.enable
			&& state_ff.s2.read_select && !state_ff.s2.instr_data_select;
	endsequence

	a_text_addr_set: // see [R01]
	assert property (s_addr_cmd ##0 !state_ff.cfg.extended_set_select |=>
		state_ff.address_counter == $past(ev_byte[6:0]) && state_ff.target == RAM_TEXT)
		else $error("text address set not taken");
	a_burst_set: // see [R04]
	assert property (s_addr_cmd ##0 state_ff.cfg.extended_set_select |=>
		state_ff.cfg.spi_burst_length == $past(ev_byte[6:0]) && state_ff.burst_left != 7'h00
		&& state_ff.burst_left <= BURST_MAX_FIELD + 7'h01)
		else $error("burst length not taken");
	a_status_value: // see [R06]
	assert property (s_status_rd |=> !db_oe_n && state_ff.cfg.bus_8bit == $past(state_ff.cfg.bus_8bit)
		&& (!state_ff.cfg.bus_8bit || db_out == {$past(state_ff.busy), $past(state_ff.address_counter)}))
		else $error("status read wrong");
	a_font_step: // see [R09]
	assert property (s_data_access ##0 state_ff.target == RAM_FONT |=>
		state_ff.address_counter[5:0] == ($past(state_ff.cfg.entry_increment) ?
		$past(state_ff.address_counter[5:0]) + 6'h01 : $past(state_ff.address_counter[5:0]) - 6'h01))
		else $error("font address step wrong");
	a_line2_wrap: // see [R02]
	assert property (s_data_access ##0 (state_ff.target == RAM_TEXT && !state_ff.cfg.four_line_mode
		&& state_ff.cfg.entry_increment && state_ff.address_counter == 7'h27) |=>
		state_ff.address_counter == 7'h40) else $error("two-line wrap wrong");
	a_line4_wrap: // see [R03]
	assert property (s_data_access ##0 (state_ff.target == RAM_TEXT && state_ff.cfg.four_line_mode
		&& state_ff.cfg.entry_increment && state_ff.address_counter == 7'h33) |=>
		state_ff.address_counter == 7'h40) else $error("four-line wrap wrong");
	a_nibble_quiet: // see [R13]
	assert property (clk_en && state_ff.s2.parallel_serial_pick && state_ff.e_prev
		&& !state_ff.s2.enable && !state_ff.cfg.bus_8bit && !state_ff.nib_phase
		&& !state_ff.busy && state_ff.s2.hw_reset_n |=> !state_ff.busy)
		else $error("busy rose on first nibble");
	a_init_busy: // see [R19]
	assert property ((state_ff.seq == SEQ_FILL)[*2] |-> busy_flag)
		else $error("busy low during init");
	a_fill_space: // see [R19]
	assert property (clk_en && state_ff.seq == SEQ_FILL |=>
		text_ram[$past(state_ff.fill_addr)] == SPACE_CODE) else $error("fill not space");
	a_init_defaults: // see [R20] [R21]
	assert property ($fell(state_ff.por_active) |-> display_cfg == CFG_RESET)
		else $error("init defaults wrong");
	a_hw_ignored: // see [R22]
	assert property (clk_en && state_ff.por_active && !state_ff.s2.hw_reset_n
		&& state_ff.fill_addr != TEXT_LAST |=> state_ff.fill_addr == $past(state_ff.fill_addr) + 7'h01)
		else $error("hardware reset acted during power-up");
	a_burst_count: // see [R18]
	assert property (clk_en && ev_exec && !ev_read && !state_ff.s2.parallel_serial_pick
		&& state_ff.s2.three_pin_pick && state_ff.burst_left != 7'h00 && state_ff.s2.hw_reset_n
		|=> state_ff.burst_left == $past(state_ff.burst_left) - 7'h01)
		else $error("burst count not consumed");
endmodule

`default_nettype wire

// ### lcdh_pkg.sv
// shared constants and types of the character display host interface
package lcdh_pkg;
	// clock rate and instruction execution time
	localparam int CLK_HZ = 40_000_000;
	localparam int EXEC_TIME_NS = 1000;
	localparam int EXEC_CYCLES_CALC = (EXEC_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// memory sizes and fill value
	localparam int TEXT_DEPTH = 128;
	localparam int FONT_DEPTH = 64;
	localparam int ICON_DEPTH = 16;
	localparam logic [6:0] TEXT_LAST = 7'h7F;
	localparam logic [7:0] SPACE_CODE = 8'h20;
	// text line maps
	localparam logic [6:0] AC_RESET = 7'h00;
	localparam logic [6:0] L2_LINE1_END = 7'h27;
	localparam logic [6:0] L2_LINE2_BASE = 7'h40;
	localparam logic [6:0] L2_LINE2_END = 7'h67;
	localparam logic [4:0] L4_LAST_COL = 5'h13;
	// burst field holding the largest count (80 writes)
	localparam logic [6:0] BURST_MAX_FIELD = 7'h4F;
	// opcode lead bits, highest first
	localparam int OP_TEXT_ADDR_BIT = 7;
	localparam int OP_FONT_ADDR_BIT = 6;
	localparam int OP_FUNC_BIT = 5;
	localparam int OP_SHIFT_BIT = 4;
	localparam int OP_DISP_BIT = 3;
	localparam int OP_ENTRY_BIT = 2;
	localparam int OP_HOME_BIT = 1;
	localparam int OP_CLEAR_BIT = 0;
	// function-set fields
	localparam int FS_WIDTH_BIT = 4;
	localparam int FS_EXT_BIT = 2;
	// serial pins on the data bus
	localparam int SER_CS_BIT = 5;
	localparam int SER_DATA_BIT = 7;

	// RAM targeted by data accesses
	typedef enum logic [1:0] {RAM_TEXT, RAM_FONT, RAM_ICON} lcdh_ram_t;
	// fill sequencer
	typedef enum logic {SEQ_IDLE, SEQ_FILL} lcdh_seq_t;

	// raw pins from the host side
	typedef struct packed {
		logic enable;
		logic instr_data_select;
		logic read_select;
		logic [7:0] db;
		logic parallel_serial_pick;
		logic three_pin_pick;
		logic hw_reset_n;
	} lcdh_pins_t;

	// configuration state seen by the display logic
	typedef struct packed {
		logic bus_8bit;
		logic extended_set_select;
		logic user_font_blink;
		logic shift_or_bank_pick;
		logic invert_all;
		logic display_on;
		logic cursor_on;
		logic blink_on;
		logic entry_increment;
		logic entry_shift;
		logic segment_order_flip;
		logic cursor_invert;
		logic four_line_mode;
		logic power_down;
		logic [1:0] code_bank;
		logic [3:0] line_scroll_enables;
		logic [6:0] spi_burst_length;
	} lcdh_cfg_t;

	localparam lcdh_cfg_t CFG_RESET = '{bus_8bit: 1'b1, entry_increment: 1'b1, default: '0};

	// system clock domain state
	typedef struct packed {
		lcdh_pins_t s1;
		lcdh_pins_t s2;
		logic e_prev;
		logic nib_phase;
		logic [3:0] nib_hi;
		lcdh_cfg_t cfg;
		logic [6:0] address_counter;
		lcdh_ram_t target;
		logic [7:0] rd_data;
		logic [7:0] busy_cnt;
		logic busy;
		lcdh_seq_t seq;
		logic [6:0] fill_addr;
		logic por_active;
		logic [6:0] burst_left;
		logic tog_s1;
		logic tog_s2;
		logic tog_seen;
		logic [7:0] db_out;
		logic db_oe_n;
	} lcdh_state_t;

	localparam lcdh_state_t ST_RESET = '{cfg: CFG_RESET, target: RAM_TEXT, busy: 1'b1,
		seq: SEQ_FILL, por_active: 1'b1, db_oe_n: 1'b1, default: '0};

	// serial link domain state
	typedef struct packed {
		logic [6:0] shreg;
		logic [7:0] buf0;
		logic [7:0] buf1;
		logic isel0;
		logic isel1;
		logic tog;
	} lcdh_link_t;

	localparam lcdh_link_t LINK_RESET = '0;
endpackage

// ### lcdh_host_model.sv
// host side model: parallel bus strobes and serial frames into the display block
`timescale 1ns/1ps
`default_nettype none
module lcdh_host_model
	import lcdh_pkg::*;
	(
	input wire logic clk,
	input wire logic [7:0] db_out,
	output var lcdh_pins_t pins
	);
	// idle pins: parallel bus, chip select high, serial clock high
	initial pins = '{hw_reset_n: 1'b1, parallel_serial_pick: 1'b1, db: 8'h60, default: '0};
	// one strobe: qualifiers held until 4 clk after enable falls
	task automatic strobe(input logic rs, input logic rd, input logic [7:0] d,
		output logic [7:0] q);
		pins.instr_data_select <= rs;
		pins.read_select <= rd;
		// released bus shows the inverse of the last value
		pins.db <= rd ? ~pins.db : d;
		pins.enable <= 1'b1;
		repeat (4) @(posedge clk);
		q = db_out;
		pins.enable <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// serial frame, msb first; fewer than 8 bits abandons the byte
	task automatic frame(input logic rs, input logic [7:0] d, input int nbits);
		pins.instr_data_select = rs;
		pins.db[5] = 1'b0;
		#7;
		for (int i = 7; i > 7 - nbits; i--)
		begin
			pins.db[6] = 1'b0;
			pins.db[7] = d[i];
			#6 pins.db[6] = 1'b1;
			#6;
		end
		// data line let go, frame closed
		pins.db[7] = ~pins.db[7];
		pins.db[5] = 1'b1;
		#7;
	endtask
endmodule
`default_nettype wire

// ### lcdh_core_tb_top.sv
// self-checking bench of the display host interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module lcdh_core_tb_top
	import lcdh_pkg::*;
	;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	lcdh_pins_t pin_bus;
	logic [7:0] db_out;
	logic db_oe_n;
	logic busy_flag;
	logic [6:0] address_counter;
	lcdh_cfg_t display_cfg;
	logic [7:0] rd;
	int errors = 0;
	int samples_checked = 0;
	// 40 MHz system clock
	always #12.5 clk = ~clk;
	lcdh_core #(.EXEC_CYCLES(2)) dut_u (.clk(clk), .clk_en(1'b1), .reset_n(reset_n),
		.serial_clk(pin_bus.db[6]), .pin_in(pin_bus), .db_out(db_out), .db_oe_n(db_oe_n),
		.busy_flag(busy_flag), .address_counter(address_counter), .display_cfg(display_cfg));
	lcdh_host_model host_u (.clk(clk), .db_out(db_out), .pins(pin_bus));
	// verdict and end of run
	task automatic summarize();
		if (errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// bounded wait for busy low
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy_flag !== 1'b0 && n < 600)
		begin
			@(posedge clk);
			n++;
		end
		if (busy_flag !== 1'b0)
		begin
			errors++;
			summarize();
		end
	endtask
	// parallel access then busy poll
	task automatic acc(input logic rs, input logic r, input logic [7:0] d);
		host_u.strobe(rs, r, d, rd);
		wait_idle();
	endtask
	// serial byte then busy poll
	task automatic sf(input logic rs, input logic [7:0] d);
		host_u.frame(rs, d, 8);
		repeat (8) @(posedge clk);
		wait_idle();
	endtask
	// power-up fill and defaults
	task automatic t_reset();
		`CHK("busy", 1'b1, busy_flag)
		// hardware reset pulse inside the power-up fill must be ignored
		host_u.pins.hw_reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		host_u.pins.hw_reset_n <= 1'b1;
		wait_idle();
		`CHK("cfg", CFG_RESET, display_cfg)
		acc(1'b0, 1'b0, 8'h80);
		acc(1'b1, 1'b1, 8'h00);
		`CHK("fill", SPACE_CODE, rd)
	endtask
	// 8-bit address set, status, write, step both ways, readback
	task automatic t_bus8();
		acc(1'b0, 1'b0, 8'hC5);
		`CHK("ac", 7'h45, address_counter)
		acc(1'b0, 1'b1, 8'h00);
		`CHK("status", 8'h45, rd)
		acc(1'b1, 1'b0, 8'h3C);
		`CHK("ac", 7'h46, address_counter)
		acc(1'b0, 1'b0, 8'h04);
		acc(1'b1, 1'b0, 8'h5A);
		`CHK("ac", 7'h45, address_counter)
		acc(1'b0, 1'b0, 8'h06);
		acc(1'b0, 1'b0, 8'hC5);
		acc(1'b1, 1'b1, 8'h00);
		`CHK("data", 8'h3C, rd)
	endtask
	// 4-bit mode: nibbles, busy only after the second
	task automatic t_bus4();
		acc(1'b0, 1'b0, 8'h20);
		`CHK("width", 1'b0, display_cfg.bus_8bit)
		host_u.strobe(1'b0, 1'b0, 8'h90, rd);
		`CHK("busy", 1'b0, busy_flag)
		`CHK("ac", 7'h46, address_counter)
		acc(1'b0, 1'b0, 8'h30);
		`CHK("ac", 7'h13, address_counter)
		host_u.strobe(1'b0, 1'b0, 8'h30, rd);
		acc(1'b0, 1'b0, 8'h00);
		`CHK("width", 1'b1, display_cfg.bus_8bit)
	endtask
	// line maps, cursor shift preload and font address wrap from 3Fh to 00h
	task automatic t_maps();
		acc(1'b0, 1'b0, 8'hA7);
		acc(1'b1, 1'b0, 8'h11);
		`CHK("ac", 7'h40, address_counter)
		acc(1'b0, 1'b0, 8'h10);
		`CHK("ac", 7'h27, address_counter)
		acc(1'b1, 1'b1, 8'h00);
		`CHK("shift rd", 8'h11, rd)
		acc(1'b0, 1'b0, 8'h34);
		acc(1'b0, 1'b0, 8'h09);
		acc(1'b0, 1'b0, 8'h30);
		`CHK("four", 1'b1, display_cfg.four_line_mode)
		acc(1'b0, 1'b0, 8'hB3);
		acc(1'b1, 1'b0, 8'h22);
		`CHK("ac", 7'h40, address_counter)
		acc(1'b0, 1'b0, 8'h7F);
		acc(1'b1, 1'b0, 8'h33);
		`CHK("ac", 7'h00, address_counter)
	endtask
	// 4-pin serial: instruction, abandoned byte, data
	task automatic t_ser4();
		host_u.pins.parallel_serial_pick <= 1'b0;
		@(posedge clk);
		sf(1'b0, 8'h8A);
		`CHK("ac", 7'h0A, address_counter)
		host_u.frame(1'b0, 8'h81, 3);
		sf(1'b0, 8'h85);
		`CHK("ac", 7'h05, address_counter)
		sf(1'b1, 8'h41);
		`CHK("ac", 7'h06, address_counter)
	endtask
	// 3-pin serial: burst length separates data from instructions
	task automatic t_ser3();
		host_u.pins.three_pin_pick <= 1'b1;
		@(posedge clk);
		sf(1'b0, 8'h34);
		`CHK("ext", 1'b1, display_cfg.extended_set_select)
		sf(1'b1, 8'h81);
		`CHK("ac", 7'h06, address_counter)
		sf(1'b0, 8'hAA);
		sf(1'b0, 8'hBB);
		`CHK("ac", 7'h08, address_counter)
		sf(1'b1, 8'h30);
		sf(1'b1, 8'h92);
		`CHK("ac", 7'h12, address_counter)
	endtask
	// hardware reset reinitialises
	task automatic t_hwrst();
		host_u.pins.parallel_serial_pick <= 1'b1;
		acc(1'b0, 1'b0, 8'h0C);
		host_u.pins.hw_reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK("busy", 1'b1, busy_flag)
		host_u.pins.hw_reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		wait_idle();
		`CHK("cfg", CFG_RESET, display_cfg)
	endtask
	// main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_bus8();
		t_bus4();
		t_maps();
		t_ser4();
		t_ser3();
		t_hwrst();
		summarize();
	end
endmodule
`default_nettype wire
